/* pkg/ffic_pkg.sv */
// ---------------------------------------------------------------------------
// Shared constants and types of the fault flag and serial command block
// ---------------------------------------------------------------------------
package ffic_pkg;

  // Clock rate and timing figures
  localparam int CLK_PERIOD_NS = 50;
  localparam int IRQ_PULSE_NS = 100_000;     // 100 us requested pulse
  localparam int IRQ_RELEASE_NS = 1_000_000; // 1.0 ms release after select falls
  // Pulse length rounds down as a longest time, never below one cycle
  localparam int IRQ_PULSE_CYC = (IRQ_PULSE_NS / CLK_PERIOD_NS < 1) ? 1 :
                                 IRQ_PULSE_NS / CLK_PERIOD_NS;
  localparam int IRQ_RELEASE_CYC = (IRQ_RELEASE_NS / CLK_PERIOD_NS < 1) ? 1 :
                                   IRQ_RELEASE_NS / CLK_PERIOD_NS;

  // Frame layout
  localparam int FRAME_BITS = 32;
  localparam logic [5:0] FRAME_BITS_CNT = 6'h20;

  // Register address codes, bits 31..25 of a command
  localparam logic [6:0] ADDR_SWITCH_STATUS = 7'h1F;
  localparam logic [6:0] ADDR_FAULT_FLAGS = 7'h21;
  localparam logic [6:0] ADDR_IRQ_PULSE_REQ = 7'h23;
  localparam logic [6:0] ADDR_SOFT_RESET_CMD = 7'h24;
  localparam logic [6:0] ADDR_LAST_VALID = 7'h24;

  // Return codes, bits 31..24 of a response
  localparam logic [7:0] RET_SWITCH_STATUS = 8'h3E;
  localparam logic [7:0] RET_FAULT_FLAGS = 8'h42;
  localparam logic [7:0] RET_IRQ_PULSE = 8'h47;

  // Field positions of the fault register and response
  localparam int BIT_FAULT_SUMMARY = 23;
  localparam int BIT_CHANGE_EVENT = 22;
  localparam int BIT_FRAME_ERROR = 10;
  localparam int BIT_CHECKSUM = 9;
  localparam int BIT_LOW_SUPPLY = 7;
  localparam int BIT_HIGH_SUPPLY = 6;
  localparam int BIT_THERMAL_WARN = 5;
  localparam int BIT_THERMAL_LIMIT = 4;
  localparam int BIT_IRQ_WAKE = 3;
  localparam int BIT_WAKE_PIN_WAKE = 2;
  localparam int BIT_SERIAL_WAKE = 1;
  localparam int BIT_POR = 0;

  // Reset value and implemented bits of the fault register
  localparam logic [23:0] FLAGS_RESET = 24'h400001;
  localparam logic [23:0] FLAGS_USED = 24'h4006FF;
  localparam logic [23:0] FAULT_BITS = 24'h0006FF;

  // Pins sampled from outside the clock domain
  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic mosi;
    logic irq_in;
    logic wake_n;
    logic low_supply;
    logic high_supply;
    logic thermal_warn;
    logic thermal_limit;
    logic por_low;
    logic [21:0] sw;
  } ffic_pins_t;

  // Serial link states
  typedef enum logic [1:0] {
    LK_IDLE = 2'b01,
    LK_FRAME = 2'b10
  } ffic_link_t;

  // Kind of response word for the next frame
  typedef enum logic [3:0] {
    RK_ECHO = 4'b0001,
    RK_STATUS = 4'b0010,
    RK_FAULT = 4'b0100,
    RK_IRQ = 4'b1000
  } ffic_resp_t;

  // Whole state of the block
  typedef struct packed {
    ffic_pins_t s1;
    ffic_pins_t s2;
    ffic_pins_t s3;
    ffic_link_t link;
    logic [31:0] rx;
    logic [31:0] tx;
    logic [5:0] cnt;
    ffic_resp_t sent_kind;
    ffic_resp_t next_kind;
    logic [7:0] echo_code;
    logic [23:0] flags;
    logic irq_hold;
    logic irq_drive;
    logic rel_run;
    logic [15:0] rel_cnt;
    logic [15:0] pulse_cnt;
    logic soft_rst;
  } ffic_state_t;

endpackage : ffic_pkg

/* design/ffic_fault_flags.sv */
`timescale 1ns/10ps

// Summary of operation
// - Bit 22 sets on change, clears on read
// - Bit 10 frame error, cleared by clean read
// - Bit 9 checksum mismatch, read clears when gone
// - Bit 7 low supply, read clears when recovered
// - Bit 6 high supply, read clears when ended
// - Bit 5 thermal warning, read clears when cool
// - Bit 4 thermal limit, read clears when cool
// - Bit 3 irq pin wakeup, read clears
// - Bit 2 wake pin falling edge, read clears
// - Bit 1 serial wakeup, read clears
// - Bit 0 power-on reset, read clears when ended
// - Interrupt command drives fixed irq pulse
// - Interrupt command answer echoes code, zero data
// - Interrupt command never sets change flag
// - Reset command restores serial registers
// - Reset answer carries switch status word
// - Fault read answered during following frame
// - Frame is select low plus 32 clocks
// - Irq released fixed time after select falls
module ffic_fault_flags
  import ffic_pkg::*;
#(
  parameter int RELEASE_CYCLES = IRQ_RELEASE_CYC, // Irq release delay in cycles
  parameter int PULSE_CYCLES = IRQ_PULSE_CYC      // Requested irq pulse in cycles
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Serial port pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  // Open-drain interrupt pin
  input wire logic irq_in,
  output logic irq_o,
  output logic irq_oe,
  // Wake pin
  input wire logic wake_in_n,
  // Analog monitor conditions, asynchronous
  input wire logic low_supply_cond,
  input wire logic high_supply_cond,
  input wire logic thermal_warn_cond,
  input wire logic thermal_limit_cond,
  input wire logic por_low_cond,
  // Switch inputs, asynchronous
  input wire logic [21:0] switch_state,
  // Same-domain device status
  input wire logic low_power_state,
  input wire logic hash_mismatch,
  // Device side outputs
  output logic cfg_reset_pulse,
  output logic [23:0] fault_flags
);

  // -------------------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------------------

  // Builds the response word for the kind chosen by the previous frame
  function automatic logic [31:0] build_resp(input ffic_resp_t kind,
                                             input logic [7:0] echo,
                                             input logic [23:0] flags,
                                             input logic [21:0] sw);
    logic [1:0] semi;
    logic [31:0] w;
    semi = {|(flags & FAULT_BITS), flags[BIT_CHANGE_EVENT]};
    w = {echo, semi, 22'h000000};
    case (kind)
      RK_STATUS: begin
        w = {RET_SWITCH_STATUS, semi, sw};
      end
      RK_FAULT: begin
        w = {RET_FAULT_FLAGS, semi, flags[21:0] & FLAGS_USED[21:0]};
      end
      RK_IRQ: begin
        w = {RET_IRQ_PULSE, semi, 22'h000000};
      end
      default: begin
        w = {echo, semi, 22'h000000};
      end
    endcase
    return w;
  endfunction : build_resp

  // -------------------------------------------------------------------------
  // State
  // -------------------------------------------------------------------------

  ffic_state_t q; // Registered state
  ffic_state_t n; // Next state
  ffic_pins_t pins; // Raw asynchronous pins

  assign pins = '{sclk: sclk, cs_n: cs_n, mosi: mosi, irq_in: irq_in,
                  wake_n: wake_in_n, low_supply: low_supply_cond,
                  high_supply: high_supply_cond, thermal_warn: thermal_warn_cond,
                  thermal_limit: thermal_limit_cond, por_low: por_low_cond,
                  sw: switch_state};

  // -------------------------------------------------------------------------
  // Next-state logic
  // -------------------------------------------------------------------------

  // Edges are taken from the second and third stages only, never the first
  always_comb begin
    logic sclk_rise;
    logic sclk_fall;
    logic cs_fall;
    logic cs_rise;
    logic good_len;
    logic good_frame;
    logic frame_err;
    logic [6:0] addr;
    logic wr;
    logic [23:0] data;
    logic [23:0] set;
    logic [23:0] clr;
    logic new_event;
    logic persist;
    sclk_rise = 1'b0;
    sclk_fall = 1'b0;
    cs_fall = 1'b0;
    cs_rise = 1'b0;
    good_len = 1'b0;
    good_frame = 1'b0;
    frame_err = 1'b0;
    addr = 7'h00;
    wr = 1'b0;
    data = 24'h000000;
    set = 24'h000000;
    clr = 24'h000000;
    new_event = 1'b0;
    persist = 1'b0;
    n = q;

    // Two-stage synchroniser plus one history stage
    n.s1 = pins;
    n.s2 = q.s1;
    n.s3 = q.s2;
    n.soft_rst = 1'b0;

    sclk_rise = q.s2.sclk & ~q.s3.sclk;
    sclk_fall = ~q.s2.sclk & q.s3.sclk;
    cs_fall = ~q.s2.cs_n & q.s3.cs_n;
    cs_rise = q.s2.cs_n & ~q.s3.cs_n;

    // Serial link: a frame runs from select low to select high
    case (q.link)
      LK_IDLE: begin
        if (cs_fall) begin
          // Load the answer chosen by the previous frame
          n.link = LK_FRAME;
          n.cnt = 6'h00;
          n.tx = build_resp(q.next_kind, q.echo_code, q.flags, q.s2.sw);
          n.sent_kind = q.next_kind;
        end
      end
      LK_FRAME: begin
        if (cs_rise) begin
          n.link = LK_IDLE;
        end else begin
          if (sclk_rise) begin
            // Sample data in, count saturates so long frames stay bad
            n.rx = {q.rx[30:0], q.s2.mosi};
            if (q.cnt != 6'h3F) begin
              n.cnt = q.cnt + 6'h01;
            end
          end
          if (sclk_fall) begin
            n.tx = {q.tx[30:0], 1'b0};
          end
        end
      end
      default: begin
        n.link = LK_IDLE;
      end
    endcase

    // Frame end: check length and address, then decode the command
    addr = q.rx[31:25];
    wr = q.rx[24];
    data = q.rx[23:0];
    if ((q.link == LK_FRAME) && cs_rise) begin
      good_len = (q.cnt == FRAME_BITS_CNT);
      good_frame = good_len && (addr <= ADDR_LAST_VALID);
      frame_err = ~good_frame;
      n.next_kind = RK_ECHO;
      n.echo_code = q.rx[31:24];
      if (good_frame) begin
        if (addr == ADDR_SWITCH_STATUS && !wr) begin
          n.next_kind = RK_STATUS;
        end else if (addr == ADDR_FAULT_FLAGS && !wr) begin
          n.next_kind = RK_FAULT;
        end else if (addr == ADDR_IRQ_PULSE_REQ && wr && data == 24'h000000) begin
          // Fixed pulse; the command itself raises no flag
          n.next_kind = RK_IRQ;
          n.pulse_cnt = 16'(PULSE_CYCLES);
        end else if (addr == ADDR_SOFT_RESET_CMD && wr && data == 24'h000000) begin
          n.next_kind = RK_STATUS;
          n.soft_rst = 1'b1;
        end
      end
      // Reads clear only once their answer has been fully shifted out
      if (good_len && q.sent_kind == RK_FAULT) begin
        clr[BIT_CHANGE_EVENT] = 1'b1;
        clr[BIT_FRAME_ERROR] = 1'b1;
        clr[BIT_CHECKSUM] = ~hash_mismatch;
        clr[BIT_LOW_SUPPLY] = ~q.s2.low_supply;
        clr[BIT_HIGH_SUPPLY] = ~q.s2.high_supply;
        clr[BIT_THERMAL_WARN] = ~q.s2.thermal_warn;
        clr[BIT_THERMAL_LIMIT] = ~q.s2.thermal_limit;
        clr[BIT_IRQ_WAKE] = 1'b1;
        clr[BIT_WAKE_PIN_WAKE] = 1'b1;
        clr[BIT_SERIAL_WAKE] = 1'b1;
        clr[BIT_POR] = 1'b1;
      end else if (good_len && q.sent_kind == RK_STATUS) begin
        clr[BIT_CHANGE_EVENT] = 1'b1;
      end
    end

    // Flag set conditions
    set[BIT_FRAME_ERROR] = frame_err;
    set[BIT_CHECKSUM] = hash_mismatch;
    set[BIT_LOW_SUPPLY] = q.s2.low_supply;
    set[BIT_HIGH_SUPPLY] = q.s2.high_supply;
    set[BIT_THERMAL_WARN] = q.s2.thermal_warn;
    set[BIT_THERMAL_LIMIT] = q.s2.thermal_limit;
    // Our own drive would look like a wake edge, so it is excluded
    set[BIT_IRQ_WAKE] = low_power_state & ~q.irq_drive &
                        ~q.s2.irq_in & q.s3.irq_in;
    set[BIT_WAKE_PIN_WAKE] = ~q.s2.wake_n & q.s3.wake_n;
    set[BIT_SERIAL_WAKE] = low_power_state & cs_fall;
    set[BIT_POR] = q.s2.por_low;
    // Any switch change or newly raised fault is a change event
    new_event = (q.s2.sw != q.s3.sw) || ((set & ~q.flags & FAULT_BITS) != 24'h000000);
    set[BIT_CHANGE_EVENT] = new_event;

    // Set wins over clear; unused bits forced low
    n.flags = ((q.flags & ~clr) | set) & FLAGS_USED;

    // Interrupt hold: released a fixed time after select falls
    persist = q.s2.low_supply | q.s2.high_supply | q.s2.thermal_warn |
              q.s2.thermal_limit | hash_mismatch;
    if (cs_fall && q.irq_hold) begin
      n.rel_run = 1'b1;
      n.rel_cnt = 16'h0000;
    end else if (q.rel_run) begin
      if (q.rel_cnt == 16'(RELEASE_CYCLES - 1)) begin
        // Reassert at once if a cause is still present
        n.rel_run = 1'b0;
        n.irq_hold = persist;
      end else begin
        n.rel_cnt = q.rel_cnt + 16'h0001;
      end
    end
    if (new_event) begin
      n.irq_hold = 1'b1;
    end

    // Requested pulse counts down to zero
    if (q.pulse_cnt != 16'h0000 && n.pulse_cnt == q.pulse_cnt) begin
      n.pulse_cnt = q.pulse_cnt - 16'h0001;
    end
    n.irq_drive = n.irq_hold | (n.pulse_cnt != 16'h0000);
  end

  // -------------------------------------------------------------------------
  // State register
  // -------------------------------------------------------------------------

  // Synchronous reset; flags come up as after a power-on event
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      q <= '0;
      q.s1.cs_n <= 1'b1;
      q.s2.cs_n <= 1'b1;
      q.s3.cs_n <= 1'b1;
      q.link <= LK_IDLE;
      q.sent_kind <= RK_ECHO;
      q.next_kind <= RK_STATUS;
      q.flags <= FLAGS_RESET;
    end else begin
      q <= n;
    end
  end

  // -------------------------------------------------------------------------
  // Outputs
  // -------------------------------------------------------------------------

  // Data out is the top of the shift register, driven only in a frame
  assign miso = q.tx[31];
  assign miso_oe = (q.link == LK_FRAME);
  // Open drain: only ever pulls low
  assign irq_o = 1'b0;
  assign irq_oe = q.irq_drive;
  assign cfg_reset_pulse = q.soft_rst;
  assign fault_flags = q.flags;

endmodule : ffic_fault_flags

/* tb/ffic_host.sv */
`timescale 1ns/10ps
// ------------------------------------------------
// Host controller model: master of the serial link
// ------------------------------------------------
module ffic_host (
  // Clock
  input wire logic ref_clk,
  // Serial pins
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  input wire logic miso
);
  // Idle link: clock stands low, select high
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  // One whole frame: command out on falls, answer sampled on rises
  task automatic xfer(input logic [31:0] c, output logic [31:0] r);
    @(posedge ref_clk);
    cs_n <= 1'b0;
    repeat (8) @(posedge ref_clk);
    for (int i = 31; i >= 0; i--) begin
      mosi <= c[i];
      repeat (4) @(posedge ref_clk);
      sclk <= 1'b1;
      r[i] = miso;
      repeat (4) @(posedge ref_clk);
      sclk <= 1'b0;
    end
    repeat (4) @(posedge ref_clk);
    cs_n <= 1'b1;
    // Released data line must not keep its last bit
    mosi <= ~c[0];
    repeat (8) @(posedge ref_clk);
  endtask : xfer
endmodule : ffic_host

/* tb/ffic_flags_monitor.sv */
`timescale 1ns/10ps
// ------------------------------------------------
// Port checks of the fault flag block
// ------------------------------------------------
module ffic_flags_monitor
  import ffic_pkg::*;
#(
  parameter int RELEASE_CYCLES = IRQ_RELEASE_CYC, // Irq release delay
  parameter int PULSE_CYCLES = IRQ_PULSE_CYC // Requested pulse length
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Serial and irq pins
  input wire logic cs_n,
  input wire logic miso_oe,
  input wire logic irq_o,
  input wire logic irq_oe,
  // Causes
  input wire logic low_supply_cond,
  input wire logic high_supply_cond,
  input wire logic thermal_warn_cond,
  input wire logic thermal_limit_cond,
  input wire logic por_low_cond,
  input wire logic hash_mismatch,
  input wire logic [21:0] switch_state,
  // Outputs
  input wire logic cfg_reset_pulse,
  input wire logic [23:0] fault_flags
);
  logic [3:0] hi_q; // Cycles since select rose, held at 15
  int rel_q; // Cycles since select fell while irq held without cause
  logic cause; // Live causes that may keep irq held
  assign cause = low_supply_cond | high_supply_cond | thermal_warn_cond
    | thermal_limit_cond | hash_mismatch;
  // Counters; a new flag or switch change restarts the hold, so no false fire
  always_ff @(posedge ref_clk) begin
    if (rst || !cs_n) begin
      hi_q <= 4'h0;
    end else if (hi_q != 4'hF) begin
      hi_q <= hi_q + 4'h1;
    end
    if (rst || !irq_oe || cause || switch_state != $past(switch_state)
        || (fault_flags & ~$past(fault_flags)) != 24'h0) begin
      rel_q <= 0;
    end else if ($fell(cs_n)) begin
      rel_q <= 1;
    end else if (rel_q != 0) begin
      rel_q <= rel_q + 1;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // A cause live long enough must show in its flag
  property p_live(c, f);
    c [*8] |-> f;
  endproperty
  // Frame opened / closed long enough for the synchroniser
  sequence s_open;
    $fell(cs_n) ##1 !cs_n [*5];
  endsequence
  sequence s_close;
    $rose(cs_n) ##1 cs_n [*7];
  endsequence
  unused_bits_a: assert property ((fault_flags & ~FLAGS_USED) == 24'h0)
    else $error("unused fault bit set");
  low_supply_a: assert property (p_live(low_supply_cond, fault_flags[BIT_LOW_SUPPLY]))
    else $error("low supply flag missing");
  high_supply_a: assert property (p_live(high_supply_cond, fault_flags[BIT_HIGH_SUPPLY]))
    else $error("high supply flag missing");
  thermal_warn_a: assert property (p_live(thermal_warn_cond, fault_flags[BIT_THERMAL_WARN]))
    else $error("thermal warning flag missing");
  thermal_limit_a: assert property (p_live(thermal_limit_cond, fault_flags[BIT_THERMAL_LIMIT]))
    else $error("thermal limit flag missing");
  por_flag_a: assert property (p_live(por_low_cond, fault_flags[BIT_POR]))
    else $error("power-on flag missing");
  hash_flag_a: assert property (p_live(hash_mismatch, fault_flags[BIT_CHECKSUM]))
    else $error("checksum flag missing");
  frame_open_a: assert property (s_open |-> miso_oe)
    else $error("data out not enabled in frame");
  frame_close_a: assert property (s_close |-> !miso_oe)
    else $error("data out enabled after frame");
  flag_clear_a: assert property (($past(fault_flags) & ~fault_flags) != 24'h0
    |-> hi_q inside {[4'h1:4'h8]}) else $error("flag cleared outside frame end");
  reset_pulse_a: assert property (cfg_reset_pulse |-> hi_q inside {[4'h1:4'h8]}
    ##1 !cfg_reset_pulse) else $error("bad register reset pulse");
  irq_release_a: assert property (rel_q <= RELEASE_CYCLES + PULSE_CYCLES + 12)
    else $error("irq not released");
  irq_pull_a: assert property (irq_oe |-> irq_o == 1'b0)
    else $error("irq driven high");
endmodule : ffic_flags_monitor

bind ffic_fault_flags ffic_flags_monitor #(.RELEASE_CYCLES(RELEASE_CYCLES),
  .PULSE_CYCLES(PULSE_CYCLES)) u_mon (.ref_clk(ref_clk), .rst(rst), .cs_n(cs_n),
  .miso_oe(miso_oe), .irq_o(irq_o), .irq_oe(irq_oe), .low_supply_cond(low_supply_cond),
  .high_supply_cond(high_supply_cond), .thermal_warn_cond(thermal_warn_cond),
  .thermal_limit_cond(thermal_limit_cond), .por_low_cond(por_low_cond),
  .hash_mismatch(hash_mismatch), .switch_state(switch_state),
  .cfg_reset_pulse(cfg_reset_pulse), .fault_flags(fault_flags));

/* tb/ffic_fault_flags_tb.sv */
`timescale 1ns/10ps
// ------------------------------------------------
// Self-checking bench of the fault flag block
// ------------------------------------------------
module ffic_fault_flags_tb
  import ffic_pkg::*;
;
  localparam int REL = 40; // Short release delay keeps the run brief
  localparam int PUL = 20; // Short irq pulse
  localparam logic [21:0] SW = 22'h2A5A5A; // Switch levels
  localparam logic [31:0] C_ST = {ADDR_SWITCH_STATUS, 1'b0, 24'h000000};
  localparam logic [31:0] C_FR = {ADDR_FAULT_FLAGS, 1'b0, 24'h000000};
  localparam logic [31:0] C_IRQ = {ADDR_IRQ_PULSE_REQ, 1'b1, 24'h000000};
  localparam logic [31:0] C_RST = {ADDR_SOFT_RESET_CMD, 1'b1, 24'h000000};
  localparam logic [31:0] NC = 32'hFFBFFFFF; // Change flag left out
  localparam logic [31:0] ALL = 32'hFFFFFFFF;
  typedef struct {logic [31:0] c; logic [31:0] e; logic [31:0] m;} ffic_row_t;
  // Command sent, answer expected in its frame (to the previous command)
  ffic_row_t rows [9] = '{
    '{C_ST, {RET_SWITCH_STATUS, 2'b11, SW}, ALL},
    '{C_FR, {RET_SWITCH_STATUS, 2'b10, SW}, ALL},
    '{C_IRQ, {RET_FAULT_FLAGS, 2'b10, 22'h000001}, ALL},
    '{C_FR, {RET_IRQ_PULSE, 24'h000000}, ALL},
    '{C_RST, {RET_FAULT_FLAGS, 24'h000000}, ALL},
    '{C_BAD_W(), {RET_SWITCH_STATUS, 2'b00, SW}, ALL},
    '{C_FR, {8'hFE, 2'b11, 22'h000000}, ALL},
    '{C_ST, {RET_FAULT_FLAGS, 2'b10, 22'h000400}, NC},
    '{C_ST, {RET_SWITCH_STATUS, 2'b00, SW}, NC}};
  int pos [7] = '{7, 6, 5, 4, 0, 9, 2}; // Flag of each cause
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic sclk, cs_n, mosi, miso, miso_oe, irq_o, irq_oe, irq_in, cfg_reset_pulse;
  logic pull_q = 1'b0; // Host pulls the irq wire
  logic lp_q = 1'b0;
  logic [6:0] cnd_q = 7'h00; // Causes; bit 6 drives the wake pin low
  logic [21:0] sw_q = SW;
  logic [23:0] fault_flags;
  logic [31:0] r;
  int errors = 0;
  int checks = 0;
  int cyc = 0;
  int pc = 0;
  int rpc = 0; // Register reset pulses seen
  int n;
  // Address beyond the last register
  function automatic logic [31:0] C_BAD_W();
    return {7'h7F, 1'b0, 24'h000000};
  endfunction : C_BAD_W
  // Open-drain wire resolved from both pullers
  assign irq_in = !((irq_oe && !irq_o) || pull_q);
  always #25 ref_clk = ~ref_clk;
  ffic_fault_flags #(.RELEASE_CYCLES(REL), .PULSE_CYCLES(PUL)) u_dut (
    .ref_clk(ref_clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso),
    .miso_oe(miso_oe), .irq_in(irq_in), .irq_o(irq_o), .irq_oe(irq_oe),
    .wake_in_n(!cnd_q[6]), .low_supply_cond(cnd_q[0]), .high_supply_cond(cnd_q[1]),
    .thermal_warn_cond(cnd_q[2]), .thermal_limit_cond(cnd_q[3]), .por_low_cond(cnd_q[4]),
    .switch_state(sw_q), .low_power_state(lp_q), .hash_mismatch(cnd_q[5]),
    .cfg_reset_pulse(cfg_reset_pulse), .fault_flags(fault_flags));
  ffic_host u_host (.ref_clk(ref_clk), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));
  // Hang guard and irq-low cycle count
  always @(posedge ref_clk) begin
    cyc++;
    if (irq_oe === 1'b1) pc++;
    if (cfg_reset_pulse === 1'b1) rpc++;
    if (cyc == 12000) begin
      errors++;
      conclude();
    end
  end
  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", w, e, s);
    end
  endtask : chk
  task automatic wt(input int k);
    repeat (k) @(posedge ref_clk);
  endtask : wt
  task automatic conclude();
    if (errors == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : conclude
  // ------------------------------------------------
  // Main sequence
  // ------------------------------------------------
  initial begin
    wt(20);
    rst <= 1'b0;
    wt(4);
    for (int i = 0; i < 9; i++) begin
      u_host.xfer(rows[i].c, r);
      if (rows[i].m != 32'h0) chk("answer", rows[i].e & rows[i].m, r & rows[i].m);
    end
    chk("reset pulses", 32'h1, 32'(rpc));
    // Each cause in turn raises its own flag
    for (int i = 0; i < 7; i++) begin
      cnd_q <= 7'h01 << i;
      wt(10);
      chk("cause flag", 32'h1, {31'h0, fault_flags[pos[i]]});
      cnd_q <= 7'h00;
      wt(4);
    end
    u_host.xfer(C_FR, r);
    u_host.xfer(C_FR, r);
    chk("flags cleared", 32'h0, {8'h0, fault_flags & FAULT_BITS});
    // Cause still live over a read keeps its flag
    cnd_q <= 7'h01;
    u_host.xfer(C_FR, r);
    u_host.xfer(C_FR, r);
    chk("held flag", 32'h1, {31'h0, fault_flags[BIT_LOW_SUPPLY]});
    cnd_q <= 7'h00;
    wt(8);
    u_host.xfer(C_ST, r);
    chk("freed flag", 32'h0, {31'h0, fault_flags[BIT_LOW_SUPPLY]});
    // Wake-ups out of low power
    lp_q <= 1'b1;
    n = 0;
    while (irq_oe !== 1'b0 && n < 400) begin
      wt(1);
      n++;
    end
    chk("irq released", 32'h0, {31'h0, irq_oe});
    pull_q <= 1'b1;
    wt(10);
    chk("irq wake", 32'h1, {31'h0, fault_flags[BIT_IRQ_WAKE]});
    pull_q <= 1'b0;
    u_host.xfer(C_ST, r);
    chk("serial wake", 32'h1, {31'h0, fault_flags[BIT_SERIAL_WAKE]});
    lp_q <= 1'b0;
    // Irq pulse length, counted after the hold has been released
    fork
      u_host.xfer(C_IRQ, r);
      begin
        wt(150);
        @(negedge ref_clk);
        n = pc;
      end
    join
    wt(60);
    @(negedge ref_clk);
    chk("pulse length", PUL, 32'(pc - n));
    // Switch change and its clearing by a status read
    sw_q <= SW ^ 22'h000001;
    wt(10);
    chk("change flag", 32'h1, {31'h0, fault_flags[BIT_CHANGE_EVENT]});
    u_host.xfer(C_ST, r);
    u_host.xfer(C_ST, r);
    chk("status answer", {RET_SWITCH_STATUS, 2'b11, SW ^ 22'h000001}, r);
    chk("change cleared", 32'h0, {31'h0, fault_flags[BIT_CHANGE_EVENT]});
    // Second reset in mid-run
    rst <= 1'b1;
    wt(2);
    rst <= 1'b0;
    wt(1);
    @(negedge ref_clk);
    chk("reset flags", {8'h0, FLAGS_RESET}, {8'h0, fault_flags});
    chk("reset pins", 32'h0, {29'h0, miso_oe, irq_oe, cfg_reset_pulse});
    conclude();
  end
endmodule : ffic_fault_flags_tb
